// [verilog/wcio_pkg.sv]
// package: register offsets, selector encodings, sizes and reset values for the io mapper
package wcio_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_INPUTS    = 32;
    localparam int NUM_OUTPUTS   = 24;
    localparam int NUM_ERRORS    = 96;
    localparam int NUM_ERR_OUTS  = 8;
    localparam int REG_WIDTH     = 16;
    localparam int REG_ADDR_W    = 16;
    localparam int ERR_SEL_W     = 4;
    localparam int ERR_IDX_W     = 7;
    localparam int FIRST_ERR_OUT = 16;
    // ==========================================================
    // holding register addresses
    localparam logic [15:0] REG_REMOTE_IN_LO  = 16'h038F;
    localparam logic [15:0] REG_REMOTE_IN_HI  = 16'h0390;
    localparam logic [15:0] REG_REMOTE_OUT_LO = 16'h0391;
    localparam logic [15:0] REG_REMOTE_OUT_HI = 16'h0392;
    localparam logic [15:0] REG_RESET_VALUE   = 16'h0000;
    localparam int          REMOTE_OUT_HI_USED = 8;
    // ==========================================================
    // output driver selection
    typedef enum logic [1:0] {
        WCIO_OUT_PRIMARY,
        WCIO_OUT_EVENT,
        WCIO_OUT_SEQUENCER,
        WCIO_OUT_REMOTE
    } wcio_out_sel_type;
    localparam logic [47:0] OUT_SEL_RESET = 48'h0000_0000_0000;
    localparam logic [31:0] IN_FUNC_RESET = 32'h0000_0000;
    localparam logic [31:0] IN_SRC_RESET  = 32'h0000_0000;
    localparam logic [7:0]  ERR_MAP_RESET = 8'h00;
    localparam logic [3:0]  ERR_NO_OUTPUT = 4'h0;
endpackage : wcio_pkg

// [verilog/wcio_out_mux.sv]
// one programmable output: four-way driver selection
module wcio_out_mux (
    // selection
    input  wire wcio_pkg::wcio_out_sel_type sel,
    // candidate levels
    input  wire logic                       primary_level,
    input  wire logic                       event_level,
    input  wire logic                       sequencer_level,
    input  wire logic                       remote_level,
    // result
    output logic                            level
);
    import wcio_pkg::*;

    always_comb begin
        case (sel)
            WCIO_OUT_PRIMARY:   level = primary_level;
            WCIO_OUT_EVENT:     level = event_level;
            WCIO_OUT_SEQUENCER: level = sequencer_level;
            WCIO_OUT_REMOTE:    level = remote_level;
            default:            level = primary_level;
        endcase
    end
endmodule : wcio_out_mux

// [verilog/wcio_mapper.sv]
// top: weld controller programmable input and output mapper
module wcio_mapper #(
    parameter int NUM_IN  = wcio_pkg::NUM_INPUTS,
    parameter int NUM_OUT = wcio_pkg::NUM_OUTPUTS
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // holding register write and read port from the communication card
    input  wire logic                              reg_wr_en,
    input  wire logic [wcio_pkg::REG_ADDR_W-1:0]   reg_addr,
    input  wire logic [wcio_pkg::REG_WIDTH-1:0]    reg_wr_data,
    input  wire logic                              reg_rd_en,
    output logic [wcio_pkg::REG_WIDTH-1:0]         reg_rd_data,
    output logic                                   reg_rd_valid,
    output logic                                   reg_addr_err,
    // configuration from the menu store
    input  wire logic [wcio_pkg::NUM_INPUTS-1:0]   input_func_seq,
    input  wire logic [wcio_pkg::NUM_INPUTS-1:0]   input_src_remote,
    input  wire logic [2*wcio_pkg::NUM_OUTPUTS-1:0] output_sel,
    input  wire logic [wcio_pkg::NUM_ERR_OUTS-1:0] output_err_map_en,
    input  wire logic [wcio_pkg::NUM_ERRORS*wcio_pkg::ERR_SEL_W-1:0] err_route,
    // local input connector groups
    input  wire logic [15:0]                       local_group_a,
    input  wire logic [15:0]                       local_group_b,
    // status sources
    input  wire logic [wcio_pkg::NUM_OUTPUTS-1:0]  primary_status,
    input  wire logic [wcio_pkg::NUM_OUTPUTS-1:0]  event_status,
    input  wire logic [wcio_pkg::NUM_OUTPUTS-1:0]  sequencer_status,
    input  wire logic [wcio_pkg::NUM_ERRORS-1:0]   error_active,
    // mapped inputs
    output logic [wcio_pkg::NUM_INPUTS-1:0]        primary_func_in,
    output logic [wcio_pkg::NUM_INPUTS-1:0]        sequencer_in,
    output logic [wcio_pkg::NUM_INPUTS-1:0]        programmable_input,
    // mapped outputs
    output logic [wcio_pkg::NUM_OUTPUTS-1:0]       programmable_output
);
    import wcio_pkg::*;

    // ==========================================================
    // elaboration checks: counts are tied to the register layout
    if (NUM_IN != NUM_INPUTS) begin : g_bad_num_in
        $error("wcio_mapper: input count is fixed by the register layout");
    end
    if (NUM_OUT != NUM_OUTPUTS) begin : g_bad_num_out
        $error("wcio_mapper: output count is fixed by the register layout");
    end

    // ==========================================================
    // holding registers
    logic [REG_WIDTH-1:0] remote_input_low_word_q;
    logic [REG_WIDTH-1:0] remote_input_high_word_q;
    logic [REG_WIDTH-1:0] remote_output_low_word_q;
    logic [REG_WIDTH-1:0] remote_output_high_byte_q;

    // each register of a multiple-register write arrives as one strobe
    logic wr_in_lo;
    logic wr_in_hi;
    logic wr_out_lo;
    logic wr_out_hi;
    always_comb begin
        wr_in_lo  = reg_wr_en && (reg_addr == REG_REMOTE_IN_LO);
        wr_in_hi  = reg_wr_en && (reg_addr == REG_REMOTE_IN_HI);
        wr_out_lo = reg_wr_en && (reg_addr == REG_REMOTE_OUT_LO);
        wr_out_hi = reg_wr_en && (reg_addr == REG_REMOTE_OUT_HI);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remote_input_low_word_q <= REG_RESET_VALUE;
        end else if (wr_in_lo) begin
            remote_input_low_word_q <= reg_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remote_input_high_word_q <= REG_RESET_VALUE;
        end else if (wr_in_hi) begin
            remote_input_high_word_q <= reg_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remote_output_low_word_q <= REG_RESET_VALUE;
        end else if (wr_out_lo) begin
            remote_output_low_word_q <= reg_wr_data;
        end
    end

    // whole word is stored and read back; only its low 8 bits drive outputs 16 to 23, the upper byte never reaches an output
    always_ff @(posedge clk) begin
        if (srst) begin
            remote_output_high_byte_q <= REG_RESET_VALUE;
        end else if (wr_out_hi) begin
            remote_output_high_byte_q <= reg_wr_data;
        end
    end

    // ==========================================================
    // read back and address check
    logic addr_hit;
    always_comb begin
        addr_hit = (reg_addr == REG_REMOTE_IN_LO) || (reg_addr == REG_REMOTE_IN_HI) ||
                   (reg_addr == REG_REMOTE_OUT_LO) || (reg_addr == REG_REMOTE_OUT_HI);
    end

    // answer strobes: one cycle after the access
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rd_valid <= 1'b0;
            reg_addr_err <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en && addr_hit;
            reg_addr_err <= (reg_rd_en || reg_wr_en) && !addr_hit;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rd_data <= REG_RESET_VALUE;
        end else if (reg_rd_en) begin
            case (reg_addr)
                REG_REMOTE_IN_LO:  reg_rd_data <= remote_input_low_word_q;
                REG_REMOTE_IN_HI:  reg_rd_data <= remote_input_high_word_q;
                REG_REMOTE_OUT_LO: reg_rd_data <= remote_output_low_word_q;
                REG_REMOTE_OUT_HI: reg_rd_data <= remote_output_high_byte_q;
                default:           reg_rd_data <= REG_RESET_VALUE;
            endcase
        end
    end

    // ==========================================================
    // input mapping
    logic [NUM_INPUTS-1:0] local_level;
    logic [NUM_INPUTS-1:0] remote_level;
    logic [NUM_INPUTS-1:0] in_level_d;
    logic [NUM_INPUTS-1:0] in_level_q;

    always_comb begin
        local_level  = {local_group_b, local_group_a};
        remote_level = {remote_input_high_word_q, remote_input_low_word_q};
        in_level_d   = (input_src_remote & remote_level) |
                       (~input_src_remote & local_level);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            in_level_q      <= IN_SRC_RESET;
            primary_func_in <= IN_FUNC_RESET;
            sequencer_in    <= IN_FUNC_RESET;
        end else begin
            in_level_q      <= in_level_d;
            primary_func_in <= in_level_d & ~input_func_seq;
            sequencer_in    <= in_level_d & input_func_seq;
        end
    end

    always_comb begin
        programmable_input = in_level_q;
    end

    // ==========================================================
    // error map onto the upper outputs
    logic [NUM_ERR_OUTS-1:0] err_map_level;
    always_comb begin
        err_map_level = ERR_MAP_RESET;
        for (int e = 0; e < NUM_ERRORS; e++) begin
            for (int o = 0; o < NUM_ERR_OUTS; o++) begin
                if (error_active[e] &&
                    err_route[e*ERR_SEL_W +: ERR_SEL_W] == 4'(o + 1)) begin
                    err_map_level[o] = 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // output mapping
    logic [NUM_OUTPUTS-1:0] remote_out_bits;
    logic [NUM_OUTPUTS-1:0] primary_eff;
    logic [NUM_OUTPUTS-1:0] out_level_d;

    always_comb begin
        remote_out_bits = {remote_output_high_byte_q[REMOTE_OUT_HI_USED-1:0],
                           remote_output_low_word_q};
        primary_eff = primary_status;
        for (int o = 0; o < NUM_ERR_OUTS; o++) begin
            if (output_err_map_en[o]) begin
                primary_eff[FIRST_ERR_OUT+o] = err_map_level[o];
            end
        end
    end

    for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
        wcio_out_mux u_mux (
            .sel             (wcio_out_sel_type'(output_sel[2*g +: 2])),
            .primary_level   (primary_eff[g]),
            .event_level     (event_status[g]),
            .sequencer_level (sequencer_status[g]),
            .remote_level    (remote_out_bits[g]),
            .level           (out_level_d[g])
        );
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            programmable_output <= OUT_SEL_RESET[NUM_OUTPUTS-1:0];
        end else begin
            programmable_output <= out_level_d;
        end
    end
endmodule : wcio_mapper

// [tb/wcio_mapper_chk.sv]
// checker: answer timing and routing relations at the mapper ports
module wcio_mapper_chk
    import wcio_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register port
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_rd_valid,
    input wire logic        reg_addr_err,
    // configuration and sources
    input wire logic [31:0] input_func_seq,
    input wire logic [31:0] input_src_remote,
    input wire logic [47:0] output_sel,
    input wire logic [7:0]  output_err_map_en,
    input wire logic [15:0] local_group_a,
    input wire logic [15:0] local_group_b,
    input wire logic [23:0] primary_status,
    input wire logic [23:0] event_status,
    // mapped results
    input wire logic [31:0] primary_func_in,
    input wire logic [31:0] sequencer_in,
    input wire logic [31:0] programmable_input,
    input wire logic [23:0] programmable_output
);
    timeunit 1ns;
    timeprecision 1ps;
    logic map_hit;
    assign map_hit = reg_addr >= REG_REMOTE_IN_LO && reg_addr <= REG_REMOTE_OUT_HI;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // assertions
    a_read_answer: assert property (reg_rd_en && map_hit |=> reg_rd_valid && !reg_addr_err)
        else $error("mapped read not answered");
    a_unmapped_err: assert property ((reg_rd_en || reg_wr_en) && !map_hit |=> reg_addr_err)
        else $error("unmapped access not flagged");
    a_no_stray_valid: assert property (!(reg_rd_en && map_hit) |=> !reg_rd_valid)
        else $error("read valid without mapped read");
    a_no_stray_err: assert property (!reg_rd_en && !reg_wr_en |=> !reg_addr_err)
        else $error("address error without access");
    a_primary_split: assert property (primary_func_in == (programmable_input & ~$past(input_func_seq)))
        else $error("primary function inputs wrong");
    a_sequencer_split: assert property (sequencer_in == (programmable_input & $past(input_func_seq)))
        else $error("sequencer inputs wrong");
    a_local_source: assert property (input_src_remote == 32'h0 |=> programmable_input == {$past(local_group_b), $past(local_group_a)})
        else $error("local inputs not routed");
    a_out_primary: assert property (output_sel == 48'h0 && output_err_map_en == 8'h00 |=> programmable_output == $past(primary_status))
        else $error("primary outputs wrong");
    a_out_event: assert property (output_sel == {24{2'h1}} |=> programmable_output == $past(event_status))
        else $error("event outputs wrong");
    c_addr_err: cover property (reg_addr_err);
    c_read: cover property (reg_rd_valid);
    c_local: cover property (input_src_remote == 32'h0 ##1 1'b1);
endmodule : wcio_mapper_chk

bind wcio_mapper wcio_mapper_chk i_wcio_mapper_chk (.*);

// [tb/wcio_remote_model.sv]
// partner: remote controller issuing holding register writes and reads
module wcio_remote_model (
    // clock
    input  wire logic   clk,
    // register port of the communication card
    output logic        reg_wr_en,
    output logic        reg_rd_en,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // released port shows inverted leftovers, never the last request
    task automatic idle();
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wr_data = ~reg_wr_data;
    endtask : idle
    initial begin
        reg_addr = 16'h0000;
        reg_wr_data = 16'h0000;
        idle();
    end
    // write-multiple frame: one strobe per register, back to back
    task automatic write_regs(input logic [15:0] first, input logic [15:0] words[$]);
        foreach (words[i]) begin
            @(negedge clk);
            reg_wr_en = 1'b1;
            reg_addr = first + 16'(i);
            reg_wr_data = words[i];
        end
        @(negedge clk);
        idle();
    endtask : write_regs
    task automatic read_reg(input logic [15:0] addr);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr = addr;
        @(negedge clk);
        idle();
    endtask : read_reg
endmodule : wcio_remote_model

// [tb/wcio_mapper_tb.sv]
// testbench: io mapper against a behavioural model
module wcio_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import wcio_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, reg_addr_err;
    logic [15:0] reg_addr, reg_wr_data, reg_rd_data, local_group_a = '0, local_group_b = '0;
    logic [31:0] input_func_seq = '0, input_src_remote = '0, primary_func_in, sequencer_in;
    logic [31:0] programmable_input, lvl;
    logic [47:0] output_sel = '0;
    logic [7:0] output_err_map_en = '0, hit;
    logic [383:0] err_route = '0;
    logic [95:0] error_active = '0;
    logic [23:0] primary_status = '0, event_status = '0, sequencer_status = '0;
    logic [23:0] programmable_output, e_out, r_out;
    logic [15:0] rg[4];
    logic [15:0] w[$];
    int seed = 87594;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    wcio_mapper i_wcio_mapper (.*);
    wcio_remote_model i_wcio_remote_model (.*);
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] exp);
        i_wcio_remote_model.read_reg(a);
        chk({15'h0, reg_rd_valid, reg_rd_data}, {16'h1, exp});
    endtask : chk_rd
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        for (int r = 0; r < 4; r++) begin
            rg[r] = REG_RESET_VALUE;
            chk_rd(REG_REMOTE_IN_LO + 16'(r), rg[r]);
        end
        i_wcio_remote_model.write_regs(16'h038E, {16'hFFFF});
        chk({31'h0, reg_addr_err}, 32'h1);
        i_wcio_remote_model.read_reg(16'h0393);
        chk({14'h0, reg_rd_valid, reg_addr_err, reg_rd_data}, {16'h0001, 16'h0000});
        $display("test reset and unmapped done");
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            input_func_seq = $random(seed);
            input_src_remote = (i % 4 == 0) ? 32'h0 : $random(seed);
            output_sel = (i % 4 == 0) ? 48'h0 : (i % 4 == 1) ? {24{2'h1}} :
                         48'({$random(seed), $random(seed)});
            output_err_map_en = (i % 4 == 0) ? 8'h00 : 8'($random(seed));
            for (int j = 0; j < 12; j++)
                err_route[32*j+:32] = $random(seed);
            error_active = {$random(seed), $random(seed), $random(seed)};
            {local_group_a, local_group_b} = $random(seed);
            {primary_status, event_status, sequencer_status} = {$random(seed), $random(seed), 8'($random(seed))};
            w = {};
            for (int r = 0; r < 4; r++)
                w.push_back(16'($random(seed)));
            i_wcio_remote_model.write_regs(REG_REMOTE_IN_LO, w);
            for (int r = 0; r < 4; r++)
                rg[r] = w[r];
            repeat (2) @(negedge clk);
            lvl = (input_src_remote & {rg[1], rg[0]}) | (~input_src_remote & {local_group_b, local_group_a});
            hit = 8'h00;
            for (int e = 0; e < NUM_ERRORS; e++)
                if (err_route[4*e+:4] inside {[4'h1:4'h8]} && error_active[e])
                    hit[int'(err_route[4*e+:4]) - 1] = 1'b1;
            r_out = {rg[3][7:0], rg[2]};
            for (int k = 0; k < NUM_OUTPUTS; k++) begin
                case (output_sel[2*k+:2])
                    2'h0: e_out[k] = (k >= 16 && output_err_map_en[k-16]) ? hit[k-16] : primary_status[k];
                    2'h1: e_out[k] = event_status[k];
                    2'h2: e_out[k] = sequencer_status[k];
                    default: e_out[k] = r_out[k];
                endcase
            end
            chk(programmable_input, lvl);
            chk(primary_func_in, lvl & ~input_func_seq);
            chk(sequencer_in, lvl & input_func_seq);
            chk({8'h00, programmable_output}, {8'h00, e_out});
            chk_rd(REG_REMOTE_IN_LO + 16'(i % 4), rg[i % 4]);
        end
        $display("test random traffic done");
        report_and_stop();
    end
endmodule : wcio_mapper_tb
